//--- ov_supervisor_pkg.sv
// Purpose: shared constants and types for the output overvoltage supervisor
// Assumes: 20 MHz core clock, command port on its own link clock
// Notes:   reset values stand in for the non-volatile defaults
package ov_supervisor_pkg;

  // ****************************************************************
  // command codes and field layout
  // ****************************************************************
  localparam logic [7:0]  CODE_FAULT_ACTION = 8'h41;
  localparam logic [7:0]  CODE_WARN_LIMIT   = 8'h42;
  localparam int          ACT_SEL_HI        = 7;
  localparam int          ACT_SEL_LO        = 6;
  localparam int          ACT_RETRY_HI      = 5;
  localparam int          ACT_RETRY_LO      = 3;
  localparam int          ACT_MULT_HI       = 2;
  localparam int          ACT_MULT_LO       = 0;
  localparam logic [1:0]  SEL_IGNORE        = 2'h0;
  localparam logic [1:0]  SEL_INVALID       = 2'h3;
  localparam logic [2:0]  RETRY_NONE        = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER     = 3'h7;

  // ****************************************************************
  // reset values and warning ratio range
  // ****************************************************************
  localparam logic [7:0]  FAULT_ACTION_RESET = 8'h80;
  localparam logic [15:0] WARN_LIMIT_RESET   = 16'h0233;
  localparam logic [6:0]  WARN_PCT_RESET     = 7'h6e;
  localparam logic [6:0]  WARN_PCT_MIN       = 7'h67;
  localparam logic [6:0]  WARN_PCT_MAX       = 7'h74;
  localparam logic [6:0]  PCT_FULL           = 7'h64;
  localparam logic [15:0] REL_ONE            = 16'h0200;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic        write;
    logic        word;
    logic [7:0]  code;
    logic [15:0] data;
  } cmd_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] data;
  } rsp_t;

  typedef enum logic [2:0] {
    ST_OFF     = 3'h0,
    ST_RISE    = 3'h1,
    ST_CHECK   = 3'h3,
    ST_ON      = 3'h2,
    ST_HICCUP  = 3'h6,
    ST_LATCHED = 3'h7
  } run_state_t;

endpackage

//--- link_port.sv
// Purpose: command port on the link clock, toggle handshake to the core
// Assumes: core updates its answer on the same edge as it toggles its acknowledge, then holds it
// Notes:   one command in flight; cmd_ready_o low while it is pending
module link_port (
  input  wire logic                        link_clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        cmd_valid_i,
  input  wire ov_supervisor_pkg::cmd_t     cmd_i,
  output logic                             cmd_ready_o,
  output logic                             rsp_valid_o,
  output ov_supervisor_pkg::rsp_t          rsp_o,
  output logic                             req_tgl_o,
  output ov_supervisor_pkg::cmd_t          cmd_o,
  input  wire logic                        ack_tgl_i,
  input  wire ov_supervisor_pkg::rsp_t     rsp_i
);
  import ov_supervisor_pkg::*;

  logic busy_reg,     busy_next;
  logic req_tgl_reg,  req_tgl_next;
  cmd_t cmd_reg,      cmd_next;
  logic ack_meta_reg, ack_sync_reg, ack_seen_reg, ack_seen_next;
  rsp_t rsp_reg,      rsp_next;
  logic rsp_vld_reg,  rsp_vld_next;

  always_comb begin
    busy_next     = busy_reg;
    req_tgl_next  = req_tgl_reg;
    cmd_next      = cmd_reg;
    ack_seen_next = ack_seen_reg;
    rsp_next      = rsp_reg;
    rsp_vld_next  = 1'b0;
    if (!busy_reg && cmd_valid_i) begin
      cmd_next     = cmd_i;
      req_tgl_next = ~req_tgl_reg;
      busy_next    = 1'b1;
    end else if (busy_reg && (ack_sync_reg != ack_seen_reg)) begin
      ack_seen_next = ack_sync_reg;
      rsp_next      = rsp_i;
      rsp_vld_next  = 1'b1;
      busy_next     = 1'b0;
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_reg     <= 1'b0;
      req_tgl_reg  <= 1'b0;
      cmd_reg      <= '0;
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
      rsp_reg      <= '0;
      rsp_vld_reg  <= 1'b0;
    end else begin
      busy_reg     <= busy_next;
      req_tgl_reg  <= req_tgl_next;
      cmd_reg      <= cmd_next;
      ack_meta_reg <= ack_tgl_i;
      ack_sync_reg <= ack_meta_reg;
      ack_seen_reg <= ack_seen_next;
      rsp_reg      <= rsp_next;
      rsp_vld_reg  <= rsp_vld_next;
    end
  end

  assign cmd_ready_o = !busy_reg;
  assign rsp_valid_o = rsp_vld_reg;
  assign rsp_o       = rsp_reg;
  assign req_tgl_o   = req_tgl_reg;
  assign cmd_o       = cmd_reg;

endmodule

//--- ov_supervisor.sv
// Purpose: output overvoltage fault response, restart control and warning
// Assumes: sense, command and rise-time inputs come from clk_i logic
// Notes:   fault comparator input is asynchronous and synchronised here
//
// Functional notes
// - overvoltage fault sets status byte, status word and vout flags, alerts host
// - action bits 7:6: 00 ignore, 01/10 shut down and retry, 11 unsupported
// - retry field zero: latch off after shutdown, never restart
// - retry 1..6: hiccup then restart, latch off after that many failed restarts
// - retry 7: hiccup and restart forever until off or success
// - hiccup period is delay field times rise time, zero meaning one
// - unsupported action or warning writes flag invalid data and notify host
// - restart succeeds after clean window past rise; counter cleared then
// - ignore action with fault present at enable prevents start-up
// - sense above warning threshold sets status word and warning flags, notifies
// - warning ratio relative to command; command changes keep stored limit
// - warning ratio rounds up to 103..116 percent in one percent steps
// - warning limit is one 16-bit read/write value shared by both output-voltage modes
// - fault monitoring runs from reset even while conversion is off
module ov_supervisor #(
  parameter int TIMER_W = 27
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        link_clk_i,
  input  wire logic                        cmd_valid_i,
  input  wire ov_supervisor_pkg::cmd_t     cmd_i,
  output logic                             cmd_ready_o,
  output logic                             rsp_valid_o,
  output ov_supervisor_pkg::rsp_t          rsp_o,
  input  wire logic                        ov_fault_i,
  input  wire logic [15:0]                 vout_sense_i,
  input  wire logic [15:0]                 vout_command_i,
  input  wire logic                        vout_mode_rel_i,
  input  wire logic [23:0]                 rise_cycles_i,
  input  wire logic [23:0]                 ton_max_cycles_i,
  input  wire logic                        enable_i,
  input  wire logic                        clear_faults_i,
  output logic                             convert_en_o,
  output logic                             latched_off_o,
  output logic [2:0]                       restart_count_o,
  output logic                             status_byte_ov_o,
  output logic                             status_word_vout_o,
  output logic                             status_word_cml_o,
  output logic                             overvoltage_fault_flag_o,
  output logic                             overvoltage_warning_value_o,
  output logic                             alert_n_o
);
  import ov_supervisor_pkg::*;

  // ****************************************************************
  // link side and crossing
  // ****************************************************************
  logic req_tgl;
  cmd_t cmd_held;
  logic ack_tgl_reg, ack_tgl_next;
  rsp_t rsp_reg,     rsp_next;
  logic req_meta_reg, req_sync_reg, req_seen_reg;

  link_port u_link (
    .link_clk_i  (link_clk_i),
    .rst_n_i     (rst_n_i),
    .cmd_valid_i (cmd_valid_i),
    .cmd_i       (cmd_i),
    .cmd_ready_o (cmd_ready_o),
    .rsp_valid_o (rsp_valid_o),
    .rsp_o       (rsp_o),
    .req_tgl_o   (req_tgl),
    .cmd_o       (cmd_held),
    .ack_tgl_i   (ack_tgl_reg),
    .rsp_i       (rsp_reg)
  );

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [7:0]  action_reg,    action_next;
  logic [15:0] warn_lim_reg,  warn_lim_next;
  logic [6:0]  warn_pct_reg,  warn_pct_next;
  logic        st_ov_reg,     st_ov_next;
  logic        st_ovw_reg,    st_ovw_next;
  logic        st_cml_reg,    st_cml_next;
  logic        flt_meta_reg,  flt_sync_reg, flt_prev_reg;

  logic        cmd_evt;
  logic        flt_rise;
  logic        warn_over;
  logic [1:0]  act_sel;
  logic [2:0]  act_retry;
  logic [2:0]  act_mult;
  logic [15:0] den;
  logic [23:0] lim_x100;
  logic [6:0]  pct_calc;
  logic        pct_ok;

  assign cmd_evt   = req_sync_reg ^ req_seen_reg;
  assign flt_rise  = flt_sync_reg && !flt_prev_reg;
  assign act_sel   = action_reg[ACT_SEL_HI:ACT_SEL_LO];
  assign act_retry = action_reg[ACT_RETRY_HI:ACT_RETRY_LO];
  assign act_mult  = action_reg[ACT_MULT_HI:ACT_MULT_LO];
  // sense*100 against command*ratio, so the stored limit is never rewritten
  assign warn_over = (vout_command_i != 16'h0000) &&
                     ({8'h00, vout_sense_i} * 24'(PCT_FULL) >
                      {8'h00, vout_command_i} * 24'(warn_pct_reg));

  // round a requested limit up to the next supported percent
  always_comb begin
    den      = vout_mode_rel_i ? REL_ONE : vout_command_i;
    lim_x100 = {8'h00, cmd_held.data} * 24'(PCT_FULL);
    pct_calc = WARN_PCT_MAX;
    pct_ok   = (den != 16'h0000) &&
               (lim_x100 <= {8'h00, den} * 24'(WARN_PCT_MAX));
    for (int p = 116; p >= 103; p--) begin
      if (lim_x100 <= {8'h00, den} * 24'(p)) begin
        pct_calc = 7'(p);
      end
    end
  end

  always_comb begin
    action_next   = action_reg;
    warn_lim_next = warn_lim_reg;
    warn_pct_next = warn_pct_reg;
    rsp_next      = rsp_reg;
    ack_tgl_next  = ack_tgl_reg;
    st_ov_next    = st_ov_reg;
    st_ovw_next   = st_ovw_reg;
    st_cml_next   = st_cml_reg;
    if (clear_faults_i) begin
      st_ov_next  = 1'b0;
      st_ovw_next = 1'b0;
      st_cml_next = 1'b0;
    end
    if (cmd_evt) begin
      ack_tgl_next = ~ack_tgl_reg;
      rsp_next     = '{ack: 1'b1, data: 16'h0000};
      if (cmd_held.code == CODE_FAULT_ACTION && !cmd_held.word) begin
        if (!cmd_held.write) begin
          rsp_next.data = {8'h00, action_reg};
        end else if (cmd_held.data[ACT_SEL_HI:ACT_SEL_LO] == SEL_INVALID) begin
          rsp_next.ack = 1'b0;
        end else begin
          action_next = cmd_held.data[7:0];
        end
      end else if (cmd_held.code == CODE_WARN_LIMIT && cmd_held.word) begin
        if (!cmd_held.write) begin
          rsp_next.data = warn_lim_reg;
        end else if (!pct_ok) begin
          rsp_next.ack = 1'b0;
        end else begin
          warn_lim_next = cmd_held.data;
          warn_pct_next = pct_calc;
        end
      end else begin
        rsp_next.ack = 1'b0;
      end
      if (!rsp_next.ack) begin
        st_cml_next = 1'b1;
      end
    end
    // hardware sets win over a same-cycle clear
    if (flt_rise) begin
      st_ov_next = 1'b1;
    end
    if (warn_over) begin
      st_ovw_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      action_reg   <= FAULT_ACTION_RESET;
      warn_lim_reg <= WARN_LIMIT_RESET;
      warn_pct_reg <= WARN_PCT_RESET;
      rsp_reg      <= '0;
      ack_tgl_reg  <= 1'b0;
      st_ov_reg    <= 1'b0;
      st_ovw_reg   <= 1'b0;
      st_cml_reg   <= 1'b0;
      flt_meta_reg <= 1'b0;
      flt_sync_reg <= 1'b0;
      flt_prev_reg <= 1'b0;
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
      req_seen_reg <= 1'b0;
    end else begin
      action_reg   <= action_next;
      warn_lim_reg <= warn_lim_next;
      warn_pct_reg <= warn_pct_next;
      rsp_reg      <= rsp_next;
      ack_tgl_reg  <= ack_tgl_next;
      st_ov_reg    <= st_ov_next;
      st_ovw_reg   <= st_ovw_next;
      st_cml_reg   <= st_cml_next;
      flt_meta_reg <= ov_fault_i;
      flt_sync_reg <= flt_meta_reg;
      flt_prev_reg <= flt_sync_reg;
      req_meta_reg <= req_tgl;
      req_sync_reg <= req_meta_reg;
      req_seen_reg <= req_sync_reg;
    end
  end

  // ****************************************************************
  // shutdown, hiccup and restart sequencing
  // ****************************************************************
  run_state_t           state_reg,   state_next;
  logic [TIMER_W-1:0]   timer_reg,   timer_next;
  logic [2:0]           restart_reg, restart_next;
  logic [TIMER_W-1:0]   rise_t;
  logic [TIMER_W-1:0]   hiccup_t;
  logic [TIMER_W-1:0]   window_t;
  logic                 shut_req;

  assign rise_t   = TIMER_W'(rise_cycles_i);
  assign hiccup_t = rise_t * TIMER_W'((act_mult == 3'h0) ? 3'h1 :
                                      act_mult);
  assign window_t = (ton_max_cycles_i != 24'h0) ? TIMER_W'(ton_max_cycles_i)
                                                : rise_t;
  assign shut_req = flt_sync_reg && (act_sel != SEL_IGNORE);

  always_comb begin
    state_next   = state_reg;
    timer_next   = timer_reg;
    restart_next = restart_reg;
    if (!enable_i) begin
      state_next   = ST_OFF;
      restart_next = 3'h0;
    end else begin
      case (state_reg)
        ST_OFF: begin
          if (!flt_sync_reg) begin
            state_next = ST_RISE;
            timer_next = '0;
          end
        end
        ST_RISE, ST_CHECK, ST_ON: begin
          timer_next = timer_reg + 1'b1;
          if (shut_req) begin
            timer_next = '0;
            if (act_retry == RETRY_NONE) begin
              state_next = ST_LATCHED;
            end else if (act_retry == RETRY_FOREVER) begin
              state_next = ST_HICCUP;
            end else if (restart_reg < act_retry) begin
              state_next   = ST_HICCUP;
              restart_next = restart_reg + 3'h1;
            end else begin
              state_next = ST_LATCHED;
            end
          end else if (state_reg == ST_RISE && timer_next >= rise_t) begin
            state_next = ST_CHECK;
            timer_next = '0;
          end else if (state_reg == ST_CHECK && timer_next >= window_t) begin
            state_next   = ST_ON;
            restart_next = 3'h0;
            timer_next   = '0;
          end else if (state_reg == ST_ON) begin
            timer_next = '0;
          end
        end
        ST_HICCUP: begin
          timer_next = timer_reg + 1'b1;
          if (timer_next >= hiccup_t) begin
            state_next = ST_RISE;
            timer_next = '0;
          end
        end
        ST_LATCHED: begin
          timer_next = '0;
        end
        default: begin
          state_next = ST_OFF;
          timer_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg   <= ST_OFF;
      timer_reg   <= '0;
      restart_reg <= 3'h0;
    end else begin
      state_reg   <= state_next;
      timer_reg   <= timer_next;
      restart_reg <= restart_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign convert_en_o       = (state_reg == ST_RISE) || (state_reg == ST_CHECK) ||
                              (state_reg == ST_ON);
  assign latched_off_o      = (state_reg == ST_LATCHED);
  assign restart_count_o    = restart_reg;
  assign status_byte_ov_o   = st_ov_reg;
  assign overvoltage_fault_flag_o         = st_ov_reg;
  assign overvoltage_warning_value_o         = st_ovw_reg;
  assign status_word_vout_o = st_ov_reg || st_ovw_reg;
  assign status_word_cml_o  = st_cml_reg;
  assign alert_n_o          = !(st_ov_reg || st_ovw_reg || st_cml_reg);

endmodule

//--- ov_supervisor_chk.sv
// Purpose: port assertions for the overvoltage supervisor
// Assumes: every watched signal except the asynchronous ov_fault_i belongs to clk_i
// Notes:   bound to the design from the bench top file
module ov_supervisor_chk (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       ov_fault_i,
  input wire logic       enable_i,
  input wire logic       convert_en_o,
  input wire logic       latched_off_o,
  input wire logic [2:0] restart_count_o,
  input wire logic       status_byte_ov_o,
  input wire logic       status_word_vout_o,
  input wire logic       status_word_cml_o,
  input wire logic       overvoltage_fault_flag_o,
  input wire logic       overvoltage_warning_value_o,
  input wire logic       alert_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_fault_held;
    $rose(ov_fault_i) ##1 ov_fault_i [*2];
  endsequence
  sequence s_enable_on_fault;
    ov_fault_i [*3] ##1 ($rose(enable_i) && ov_fault_i);
  endsequence
  property p_ov_flag;
    s_fault_held |-> ##[0:3] overvoltage_fault_flag_o;
  endproperty
  property p_ov_report;
    overvoltage_fault_flag_o |-> status_byte_ov_o && status_word_vout_o && !alert_n_o;
  endproperty
  property p_warn_report;
    overvoltage_warning_value_o |-> status_word_vout_o && !alert_n_o;
  endproperty
  property p_cml_alert;
    status_word_cml_o |-> !alert_n_o;
  endproperty
  property p_alert_cause;
    !alert_n_o |-> overvoltage_fault_flag_o || overvoltage_warning_value_o || status_word_cml_o;
  endproperty
  property p_latch_off;
    latched_off_o |-> !convert_en_o;
  endproperty
  property p_latch_hold;
    latched_off_o && enable_i |=> latched_off_o;
  endproperty
  property p_count_clear;
    !enable_i |=> restart_count_o == 3'h0 && !latched_off_o;
  endproperty
  property p_no_start;
    s_enable_on_fault |-> !convert_en_o [*3];
  endproperty
  a_ov_flag: assert property (p_ov_flag)
    else $error("fault flag not set");
  a_ov_report: assert property (p_ov_report)
    else $error("fault not reported");
  a_warn_report: assert property (p_warn_report)
    else $error("warning not reported");
  a_cml_alert: assert property (p_cml_alert)
    else $error("invalid data not notified");
  a_alert_cause: assert property (p_alert_cause)
    else $error("alert without cause");
  a_latch_off: assert property (p_latch_off)
    else $error("converting while latched");
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch left while enabled");
  a_count_clear: assert property (p_count_clear)
    else $error("count kept while disabled");
  a_no_start: assert property (p_no_start)
    else $error("started into a fault");
endmodule

//--- pmbus_host_model.sv
// Purpose: host model issuing commands on the link port
// Assumes: bench holds go_i until done_o, then drops it
// Notes:   idle command lines toggle every cycle
module pmbus_host_model (
  input  wire logic                    link_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    go_i,
  input  wire ov_supervisor_pkg::cmd_t req_i,
  output logic                         done_o,
  output ov_supervisor_pkg::rsp_t      ans_o,
  output logic                         cmd_valid_o,
  output ov_supervisor_pkg::cmd_t      cmd_o,
  input  wire logic                    cmd_ready_i,
  input  wire logic                    rsp_valid_i,
  input  wire ov_supervisor_pkg::rsp_t rsp_i
);
  timeunit 1ns;
  timeprecision 1ns;
  import ov_supervisor_pkg::*;
  logic busy;
  always @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_valid_o <= 1'b0;
      cmd_o <= '0;
      busy <= 1'b0;
      done_o <= 1'b0;
      ans_o <= '0;
    end else begin
      if (cmd_valid_o && cmd_ready_i) begin
        cmd_valid_o <= 1'b0;
        cmd_o <= ~cmd_o;
      end else if (!cmd_valid_o && !busy && go_i && !done_o) begin
        cmd_valid_o <= 1'b1;
        cmd_o <= req_i;
        busy <= 1'b1;
      end else if (!cmd_valid_o) begin
        cmd_o <= ~cmd_o;
      end
      if (busy && rsp_valid_i) begin
        ans_o <= rsp_i;
        done_o <= 1'b1;
        busy <= 1'b0;
      end else if (!go_i) begin
        done_o <= 1'b0;
      end
    end
  end
endmodule

//--- ov_supervisor_bench.sv
// Purpose: self-checking bench for the overvoltage supervisor
// Assumes: rise time 4 cycles, turn-on limit off, relative format until t_warn switches to absolute
// Notes:   registers reached through the host model
module ov_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ov_supervisor_pkg::*;
  logic clk_i, link_clk_i, rst_n_i, fault, en, clr_i, go, done, rel;
  logic cvalid, cready, rvalid, conv, latch, sbo, swv, cml, ovf, ovw, alert_n;
  logic [2:0] cnt;
  logic [15:0] sense, command;
  cmd_t req, cmd;
  rsp_t rsp, ans;
  int fail_count, checked;
  ov_supervisor dut (.clk_i, .rst_n_i, .link_clk_i, .cmd_valid_i(cvalid),
    .cmd_i(cmd), .cmd_ready_o(cready), .rsp_valid_o(rvalid), .rsp_o(rsp),
    .ov_fault_i(fault), .vout_sense_i(sense), .vout_command_i(command),
    .vout_mode_rel_i(rel), .rise_cycles_i(24'h000004),
    .ton_max_cycles_i(24'h000000), .enable_i(en), .clear_faults_i(clr_i),
    .convert_en_o(conv), .latched_off_o(latch), .restart_count_o(cnt),
    .status_byte_ov_o(sbo), .status_word_vout_o(swv),
    .status_word_cml_o(cml), .overvoltage_fault_flag_o(ovf), .overvoltage_warning_value_o(ovw),
    .alert_n_o(alert_n));
  pmbus_host_model host (.link_clk_i, .rst_n_i, .go_i(go), .req_i(req),
    .done_o(done), .ans_o(ans), .cmd_valid_o(cvalid), .cmd_o(cmd),
    .cmd_ready_i(cready), .rsp_valid_i(rvalid), .rsp_i(rsp));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk_bit(input logic g, input logic e, input string m);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e, input string m);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wait_conv(input logic v, output int n);
    n = 0;
    while (conv !== v && n < 400) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic xfer(input logic we, input logic w, input logic [7:0] c,
                      input logic [15:0] d);
    int n;
    n = 0;
    req = '{write: we, word: w, code: c, data: d};
    go = 1'b1;
    while (done !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk_bit(done, 1'b1, "no answer");
    go = 1'b0;
    while (done !== 1'b0 && n < 200) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic w, input logic [15:0] e);
    xfer(1'b0, w, c, 16'h0000);
    chk_bit(ans.ack, 1'b1, "read ack");
    chk_word(ans.data, e, "read data");
  endtask
  task automatic wr(input logic [7:0] c, input logic w, input logic [15:0] d,
                    input logic e);
    xfer(1'b1, w, c, d);
    chk_bit(ans.ack, e, "write ack");
  endtask
  task automatic clear_flags;
    clr_i = 1'b1;
    cyc(1);
    clr_i = 1'b0;
    cyc(2);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    rd(CODE_FAULT_ACTION, 1'b0, {8'h00, FAULT_ACTION_RESET});
    rd(CODE_WARN_LIMIT, 1'b1, WARN_LIMIT_RESET);
    wr(CODE_WARN_LIMIT, 1'b1, 16'h0260, 1'b0);
    chk_bit(cml, 1'b1, "invalid flag");
    chk_bit(alert_n, 1'b0, "invalid alert");
    wr(CODE_FAULT_ACTION, 1'b0, 16'h00c0, 1'b0);
    wr(CODE_FAULT_ACTION, 1'b1, 16'h0040, 1'b0);
    xfer(1'b0, 1'b1, 8'h43, 16'h0000);
    chk_bit(ans.ack, 1'b0, "unmapped read");
    rd(CODE_WARN_LIMIT, 1'b1, WARN_LIMIT_RESET);
    rd(CODE_FAULT_ACTION, 1'b0, {8'h00, FAULT_ACTION_RESET});
    clear_flags();
    chk_bit(alert_n, 1'b1, "alert after clear");
    $display("test regs done");
  endtask
  task automatic t_warn;
    logic [15:0] lim [4] = '{16'h0100, 16'h0210, 16'h0250, 16'h0250};
    logic [15:0] cmdv [4] = '{16'h03e8, 16'h03e8, 16'h03e8, 16'h0600};
    logic [15:0] edg [4] = '{16'h0406, 16'h0410, 16'h0488, 16'h06f5};
    for (int i = 0; i < 4; i++) begin
      command = cmdv[i];
      wr(CODE_WARN_LIMIT, 1'b1, lim[i], 1'b1);
      sense = edg[i];
      cyc(4);
      chk_bit(ovw, 1'b0, "warn at limit");
      sense = edg[i] + 16'h0001;
      cyc(4);
      chk_bit(ovw, 1'b1, "warn above limit");
      chk_bit(swv, 1'b1, "warn status word");
      sense = 16'h0300;
      cyc(4);
      clear_flags();
    end
    rd(CODE_WARN_LIMIT, 1'b1, 16'h0250);
    rel = 1'b0;
    command = 16'h03e8;
    wr(CODE_WARN_LIMIT, 1'b1, 16'h0410, 1'b1);
    command = 16'h0600;
    sense = 16'h063d;
    cyc(4);
    chk_bit(ovw, 1'b0, "abs at limit");
    sense = 16'h063e;
    cyc(4);
    chk_bit(ovw, 1'b1, "abs above limit");
    sense = 16'h0300;
    rd(CODE_WARN_LIMIT, 1'b1, 16'h0410);
    clear_flags();
    command = 16'h03e8;
    $display("test warn done");
  endtask
  task automatic t_latch;
    wr(CODE_FAULT_ACTION, 1'b0, 16'h0040, 1'b1);
    fault = 1'b1;
    cyc(8);
    chk_bit(latch, 1'b1, "latched");
    chk_bit(sbo, 1'b1, "status byte");
    chk_bit(ovf, 1'b1, "vout flag");
    fault = 1'b0;
    cyc(30);
    chk_bit(latch, 1'b1, "still latched");
    en = 1'b0;
    cyc(2);
    clear_flags();
    fault = 1'b1;
    cyc(6);
    chk_bit(ovf, 1'b1, "flag while off");
    fault = 1'b0;
    cyc(4);
    clear_flags();
    en = 1'b1;
    cyc(12);
    chk_bit(conv, 1'b1, "restart by enable");
    $display("test latch done");
  endtask
  task automatic t_retry;
    int n;
    wr(CODE_FAULT_ACTION, 1'b0, 16'h0053, 1'b1);
    fault = 1'b1;
    wait_conv(1'b0, n);
    chk_word({13'h0000, cnt}, 16'h0001, "first count");
    wait_conv(1'b1, n);
    chk_bit(n >= 11 && n <= 13, 1'b1, "hiccup length");
    cyc(100);
    chk_bit(latch, 1'b1, "latched after retries");
    chk_word({13'h0000, cnt}, 16'h0002, "final count");
    fault = 1'b0;
    en = 1'b0;
    cyc(4);
    clear_flags();
    en = 1'b1;
    $display("test retry done");
  endtask
  task automatic t_forever;
    wr(CODE_FAULT_ACTION, 1'b0, 16'h0048, 1'b1);
    fault = 1'b1;
    cyc(4);
    chk_word({13'h0000, cnt}, 16'h0001, "one attempt");
    fault = 1'b0;
    cyc(40);
    chk_word({13'h0000, cnt}, 16'h0000, "count after success");
    wr(CODE_FAULT_ACTION, 1'b0, 16'h00b8, 1'b1);
    cyc(20);
    fault = 1'b1;
    cyc(300);
    chk_bit(latch, 1'b0, "never latches");
    fault = 1'b0;
    cyc(40);
    chk_bit(conv, 1'b1, "restart success");
    chk_word({13'h0000, cnt}, 16'h0000, "count cleared");
    clear_flags();
    $display("test forever done");
  endtask
  task automatic t_ignore;
    wr(CODE_FAULT_ACTION, 1'b0, 16'h0000, 1'b1);
    fault = 1'b1;
    cyc(10);
    chk_bit(conv, 1'b1, "ignore keeps running");
    chk_bit(ovf, 1'b1, "ignore still flags");
    en = 1'b0;
    cyc(3);
    en = 1'b1;
    cyc(20);
    chk_bit(conv, 1'b0, "no start into fault");
    fault = 1'b0;
    cyc(10);
    chk_bit(conv, 1'b1, "start after fault");
    $display("test ignore done");
  endtask
  // ****************************************
  // run control
  // ****************************************
  task automatic end_sim;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7;
    forever #80 link_clk_i = ~link_clk_i;
  end
  initial begin
    #600000;
    fail_count++;
    $display("mismatch %0t watchdog", $time);
    end_sim();
  end
  initial begin
    fail_count = 0;
    checked = 0;
    {rst_n_i, fault, en, clr_i, go, rel} = 6'h01;
    sense = 16'h0300;
    command = 16'h03e8;
    req = '0;
    cyc(10);
    rst_n_i = 1'b1;
    cyc(1);
    chk_bit(alert_n, 1'b1, "alert idle");
    en = 1'b1;
    cyc(20);
    t_regs();
    t_warn();
    t_latch();
    t_retry();
    t_forever();
    t_ignore();
    end_sim();
  end
endmodule
bind ov_supervisor ov_supervisor_chk chk (.clk_i, .rst_n_i, .ov_fault_i,
  .enable_i, .convert_en_o, .latched_off_o, .restart_count_o,
  .status_byte_ov_o, .status_word_vout_o, .status_word_cml_o,
  .overvoltage_fault_flag_o, .overvoltage_warning_value_o, .alert_n_o);
